/* core/glrif_pkg.sv */
// Package: constants and carrier types for the genlock reference input front end
package glrif_pkg;
   localparam int GLRIF_SYNC_STAGES = 2;
   localparam int GLRIF_CNT_W = 24;
   // Longest plausible line/frame period in core clocks before the reference counts as lost
   localparam int GLRIF_CLK_MHZ = 200;
   localparam int GLRIF_H_LOST_US = 200;
   localparam int GLRIF_V_LOST_MS = 50;
   localparam int GLRIF_H_LOST_CYC = GLRIF_H_LOST_US * GLRIF_CLK_MHZ;
   localparam int GLRIF_V_LOST_CYC = GLRIF_V_LOST_MS * 1000 * GLRIF_CLK_MHZ;
   localparam logic GLRIF_POL_RST = 1'b0;
   localparam logic [3:0] GLRIF_CAD_RST = 4'h0;
   localparam logic [2:0] GLRIF_CAD_LAST = 3'h4;

   typedef struct packed {
      logic h;
      logic v;
      logic fid;
   } glrif_ref_t;

   typedef struct packed {
      logic h_lead;
      logic v_lead;
      logic fid_mark;
   } glrif_evt_t;

   typedef enum logic [1:0] {
      GLRIF_ST_FREE = 2'b00,
      GLRIF_ST_LOCK = 2'b01,
      GLRIF_ST_FREEZE = 2'b10
   } glrif_state_t;
endpackage

/* core/glrif_pol_edge.sv */
// Module: polarity sensing and leading-edge detection for one synchronised reference line
`timescale 1ns/10ps
module glrif_pol_edge
   import glrif_pkg::*;
#(
   parameter int CNT_W = GLRIF_CNT_W
) (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic level,
   output logic polarity,
   output logic lead
);
   logic prev;
   logic [CNT_W-1:0] high_cnt;
   logic [CNT_W-1:0] low_cnt;
   logic next_pol;

   // Sync pulse is the shorter phase: whichever level lasted less is the active one
   always_comb begin
      next_pol = polarity;
      if (prev && !level) begin
         next_pol = (high_cnt < low_cnt) ? 1'b1 : 1'b0;
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         prev <= 1'b0;
         high_cnt <= '0;
         low_cnt <= '0;
         polarity <= GLRIF_POL_RST;
         lead <= 1'b0;
      end else begin
         prev <= level;
         polarity <= next_pol;
         if (level) begin
            if (!prev) high_cnt <= CNT_W'(1);
            else if (high_cnt != '1) high_cnt <= high_cnt + CNT_W'(1);
         end else begin
            if (prev) low_cnt <= CNT_W'(1);
            else if (low_cnt != '1) low_cnt <= low_cnt + CNT_W'(1);
         end
         // Leading edge: transition into the active level, whatever the source timing style
         lead <= (level != prev) && (level == next_pol);
      end
   end
endmodule

/* core/glrif_front.sv */
// Module: genlock reference input front end (top)
`timescale 1ns/10ps
module glrif_front
   import glrif_pkg::*;
#(
   parameter int SYNC_STAGES = GLRIF_SYNC_STAGES,
   parameter int H_LOST_CYC = GLRIF_H_LOST_CYC,
   parameter int V_LOST_CYC = GLRIF_V_LOST_CYC
) (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic genlock_en,
   input wire logic hsync_ref,
   input wire logic vsync_ref,
   input wire logic ten_field_ident_ref,
   output glrif_evt_t ref_evt,
   output logic h_polarity,
   output logic v_polarity,
   output logic [2:0] cadence_phase,
   output logic av_phase_field,
   output logic ref_missing,
   output logic freeze
);
   localparam int LW = 32;
   glrif_ref_t sync_pipe [SYNC_STAGES];
   glrif_ref_t ref_s;
   logic en_m;
   logic en_s;
   localparam int NCH = 2;
   logic [NCH-1:0] ch_level;
   logic [NCH-1:0] ch_pol;
   logic [NCH-1:0] ch_lead;
   logic [NCH-1:0] ch_ok;
   logic h_pol;
   logic v_pol;
   logic h_lead;
   logic v_lead;
   logic fid_prev;
   logic h_ok;
   logic v_ok;
   glrif_state_t state;
   glrif_state_t next_state;

   // Chain per stage; only the last stage feeds logic
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         for (int i = 0; i < SYNC_STAGES; i++) sync_pipe[i] <= '0;
         en_m <= 1'b0;
         en_s <= 1'b0;
      end else begin
         sync_pipe[0] <= '{h: hsync_ref, v: vsync_ref, fid: ten_field_ident_ref};
         for (int i = 1; i < SYNC_STAGES; i++) sync_pipe[i] <= sync_pipe[i-1];
         en_m <= genlock_en;
         en_s <= en_m;
      end
   end
   assign ref_s = sync_pipe[SYNC_STAGES-1];

   assign ch_level = {ref_s.v, ref_s.h};

   // One timing channel per reference line: index 0 horizontal, index 1 vertical
   for (genvar c = 0; c < NCH; c++) begin : g_ch
      localparam int LIMIT = (c == 0) ? H_LOST_CYC : V_LOST_CYC;
      logic [LW-1:0] gap;

      glrif_pol_edge u_pe (
         .core_clk(core_clk),
         .rst(rst),
         .level(ch_level[c]),
         .polarity(ch_pol[c]),
         .lead(ch_lead[c])
      );

      // Loss watchdog starts saturated, so an absent reference reads as missing until its first edge
      always_ff @(posedge core_clk or posedge rst) begin
         if (rst) begin
            gap <= '1;
         end else if (ch_lead[c]) begin
            gap <= '0;
         end else if (gap != '1) begin
            gap <= gap + LW'(1);
         end
      end
      assign ch_ok[c] = gap < LW'(LIMIT);
   end

   assign h_pol = ch_pol[0];
   assign v_pol = ch_pol[1];
   assign h_lead = ch_lead[0];
   assign v_lead = ch_lead[1];
   assign h_ok = ch_ok[0];
   assign v_ok = ch_ok[1];

   always_comb begin
      next_state = state;
      case (state)
         GLRIF_ST_FREE: if (en_s && h_ok && v_ok) next_state = GLRIF_ST_LOCK;
         GLRIF_ST_LOCK: begin
            if (!en_s) next_state = GLRIF_ST_FREE;
            else if (!(h_ok && v_ok)) next_state = GLRIF_ST_FREEZE;
         end
         GLRIF_ST_FREEZE: begin
            if (!en_s) next_state = GLRIF_ST_FREE;
            else if (h_ok && v_ok) next_state = GLRIF_ST_LOCK;
         end
         default: next_state = GLRIF_ST_FREE;
      endcase
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         state <= GLRIF_ST_FREE;
         ref_missing <= 1'b1;
         freeze <= 1'b0;
      end else begin
         state <= next_state;
         ref_missing <= !(h_ok && v_ok);
         freeze <= (next_state == GLRIF_ST_FREEZE);
      end
   end

   // Timing events only pass while locked; freeze holds downstream timing by silence
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         ref_evt <= '0;
         h_polarity <= GLRIF_POL_RST;
         v_polarity <= GLRIF_POL_RST;
      end else begin
         ref_evt.h_lead <= h_lead && (state == GLRIF_ST_LOCK);
         ref_evt.v_lead <= v_lead && (state == GLRIF_ST_LOCK);
         ref_evt.fid_mark <= v_lead && ref_s.fid && (state == GLRIF_ST_LOCK);
         h_polarity <= h_pol;
         v_polarity <= v_pol;
      end
   end

   // Ten-field ident high at a field start marks field zero; low input just free-runs the cadence
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         fid_prev <= 1'b0;
         cadence_phase <= GLRIF_CAD_RST[2:0];
         av_phase_field <= 1'b0;
      end else begin
         fid_prev <= ref_s.fid;
         if (v_lead) begin
            av_phase_field <= ref_s.fid;
            if (ref_s.fid && !fid_prev) cadence_phase <= 3'h0;
            else if (ref_s.fid) cadence_phase <= 3'h0;
            else if (cadence_phase == GLRIF_CAD_LAST) cadence_phase <= 3'h0;
            else cadence_phase <= cadence_phase + 3'h1;
         end
      end
   end
endmodule

/* testbench/glrif_front_chk.sv */
// Checker: port-level assertions for the reference input front end
`timescale 1ns/10ps
module glrif_front_chk
   import glrif_pkg::*;
(
   input wire logic core_clk,
   input wire logic rst,
   input wire logic genlock_en,
   input wire logic hsync_ref,
   input wire logic vsync_ref,
   input wire glrif_evt_t ref_evt,
   input wire logic [2:0] cadence_phase,
   input wire logic ref_missing,
   input wire logic freeze
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (rst);
   h_pulse_a: assert property (ref_evt.h_lead |=> !ref_evt.h_lead)
      else $error("h lead too wide");
   // Pin pulses outlast the window, so exactly one pin edge explains each event
   h_cause_a: assert property (ref_evt.h_lead |-> $past(hsync_ref, 2) != $past(hsync_ref, 7))
      else $error("h lead without pin edge");
   v_cause_a: assert property (ref_evt.v_lead |-> $past(vsync_ref, 2) != $past(vsync_ref, 7))
      else $error("v lead without pin edge");
   idle_quiet_a: assert property (!genlock_en [*8] |-> ref_evt == '0)
      else $error("event outside genlock");
   freeze_quiet_a: assert property (freeze [*2] |-> ref_evt == '0)
      else $error("event while frozen");
   frz_missing_a: assert property (freeze |-> ref_missing)
      else $error("freeze without lost reference");
   fid_pair_a: assert property (ref_evt.fid_mark |-> ref_evt.v_lead)
      else $error("ident mark off field start");
   cad_range_a: assert property (cadence_phase <= GLRIF_CAD_LAST)
      else $error("cadence out of range");
   cad_step_a: assert property ($changed(cadence_phase) |->
      cadence_phase == 3'h0 || cadence_phase == $past(cadence_phase) + 3'h1)
      else $error("cadence skipped");
endmodule
bind glrif_front glrif_front_chk chk_i (.core_clk(core_clk), .rst(rst), .genlock_en(genlock_en),
   .hsync_ref(hsync_ref), .vsync_ref(vsync_ref), .ref_evt(ref_evt), .cadence_phase(cadence_phase),
   .ref_missing(ref_missing), .freeze(freeze));

/* testbench/glrif_src.sv */
// Partner model: sync separator giving H, V and ten-field ident
`timescale 1ns/10ps
module glrif_src
   import glrif_pkg::*;
(
   input wire logic core_clk,
   input wire logic run,
   input wire logic pol_h,
   input wire logic pol_v,
   input wire logic [7:0] hper,
   output glrif_ref_t pins = '0,
   output int fld = 0
);
   int hc = 0;
   int ln = 0;
   wire logic top = hc == 0 && ln == 0;
   always @(posedge core_clk) begin
      if (run) begin
         hc <= hc + 1 >= hper ? 0 : hc + 1;
         if (hc + 1 >= hper) ln <= (ln + 1) % 8;
         if (top) fld <= fld + 1;
      end
      // Stopped lines sit inactive, a clean loss rather than a stuck pulse
      pins.h <= pol_h ~^ (run && hc < 6);
      pins.v <= pol_v ~^ (run && ln == 0);
      pins.fid <= run && ln == 0 && (top ? fld + 1 : fld) % 10 == 0;
   end
endmodule

/* testbench/genlock_reference_input_front_bench.sv */
// Bench: front end fed by the sync source model, note queue plus output watcher
`timescale 1ns/10ps
module genlock_reference_input_front_bench;
   import glrif_pkg::*;
   typedef struct packed {logic hp; logic vp; logic fid; logic [2:0] cad;} glrif_note_t;
   logic core_clk = 1'b0, rst = 1'b1, genlock_en = 1'b0, run = 1'b0, chk_on = 1'b0;
   logic pol_h = 1'b1, pol_v = 1'b1;
   logic [7:0] hper = 8'h28;
   logic [5:0] ed = 6'h00;
   logic h_polarity, v_polarity, av_phase_field, ref_missing, freeze;
   logic [2:0] cadence_phase;
   glrif_ref_t pins;
   glrif_evt_t ref_evt;
   glrif_note_t q[$];
   glrif_note_t n;
   int fld, fld_q = 0, error_cnt = 0, cmp_count = 0, cyc = 0, hn = 0, hseen = 0;
   always #2.5 core_clk = ~core_clk;
   glrif_src src (.core_clk(core_clk), .run(run), .pol_h(pol_h), .pol_v(pol_v), .hper(hper), .pins(pins), .fld(fld));
   glrif_front #(.H_LOST_CYC(200), .V_LOST_CYC(5000)) uut (.core_clk(core_clk), .rst(rst),
      .genlock_en(genlock_en), .hsync_ref(pins.h), .vsync_ref(pins.v), .ten_field_ident_ref(pins.fid),
      .ref_evt(ref_evt), .h_polarity(h_polarity), .v_polarity(v_polarity), .cadence_phase(cadence_phase),
      .av_phase_field(av_phase_field), .ref_missing(ref_missing), .freeze(freeze));
   task automatic chk(input string what, input logic [3:0] seen, input logic [3:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         error_cnt++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic give_verdict();
      $display("Comparisons %0d, mismatches %0d", cmp_count, error_cnt);
      if (error_cnt == 0 && cmp_count > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   // Note each new field as the source starts it
   always @(posedge core_clk) begin
      fld_q <= fld;
      if (chk_on && fld != fld_q) q.push_back('{pol_h, pol_v, 1'(fld % 10 == 0), 3'(fld % 5)});
   end
   // Judge three cycles after each field event so registered status has settled
   always @(posedge core_clk) begin
      ed <= {ed[3:0], ref_evt.v_lead, ref_evt.fid_mark};
      // Line events per field; the source model draws eight lines to a field
      hn <= ref_evt.v_lead ? int'(ref_evt.h_lead) : hn + int'(ref_evt.h_lead);
      if (ref_evt.v_lead) hseen <= hn;
      if (ed[5] && q.size() > 0) begin
         n = q.pop_front();
         chk("h_polarity", 4'(h_polarity), 4'(n.hp));
         chk("v_polarity", 4'(v_polarity), 4'(n.vp));
         chk("h_per_field", 4'(hseen), 4'h8);
         chk("fid_mark", 4'(ed[4]), 4'(n.fid));
         chk("av_phase_field", 4'(av_phase_field), 4'(n.fid));
         chk("cadence_phase", 4'(cadence_phase), 4'(n.cad));
      end
   end
   always @(posedge core_clk) begin
      cyc <= cyc + 1;
      if (cyc == 60000) begin
         error_cnt++;
         $display("[ERR] run_time expected 0 seen 1");
         give_verdict();
      end
   end
   initial begin
      void'($urandom(45253));
      repeat (5) @(posedge core_clk);
      rst <= 1'b0;
      genlock_en <= 1'b1;
      run <= 1'b1;
      for (int i = 0; i < 4; i++) begin
         pol_h <= i[0];
         pol_v <= i[1];
         hper <= 8'($urandom_range(60, 30));
         // Long enough for polarity to settle and a ten-field ident to realign the cadence
         repeat (7000) @(posedge core_clk);
         q.delete();
         chk_on <= 1'b1;
         repeat (5000) @(posedge core_clk);
         chk_on <= 1'b0;
         repeat (16) @(posedge core_clk);
      end
      run <= 1'b0;
      for (int k = 0; k < 400 && freeze !== 1'b1; k++) @(posedge core_clk);
      chk("freeze", 4'(freeze), 4'h1);
      chk("ref_missing", 4'(ref_missing), 4'h1);
      run <= 1'b1;
      for (int k = 0; k < 2000 && (freeze !== 1'b0 || ref_missing !== 1'b0); k++) @(posedge core_clk);
      chk("ref_missing", 4'(ref_missing), 4'h0);
      genlock_en <= 1'b0;
      repeat (2000) @(posedge core_clk);
      chk("freeze", 4'(freeze), 4'h0);
      give_verdict();
   end
endmodule
